// file: bench/fed_front_end_tb.sv
// Self-checking bench for the fetch and decode front end
`timescale 1ns/1ps
`default_nettype none
module fed_front_end_tb
  import fed_pkg::*;
;
  typedef struct packed {
    logic         lm;
    logic [31:0]  code;
    fed_slot_type exp;
  } fed_row_type;
  logic                     clock = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     ce = 1'b1;
  logic                     long_mode = 1'b0;
  logic                     redirect = 1'b0;
  logic                     dec_ready = 1'b0;
  logic                     vec_chk = 1'b0;
  logic [63:0]              redirect_addr = '0;
  logic [PKT_BITS-1:0]      image = '0;
  logic [31:0]              vcsw = '0;
  logic [3:0]               addr_lo = '0;
  logic [3:0]               delay = '0;
  logic                     pkt_valid;
  logic [PKT_BITS-1:0]      pkt_data;
  logic                     fetch_req;
  logic [63:0]              fetch_addr;
  fed_slot_type [SLOTS-1:0] slot;
  logic                     gp_fault;
  logic [4:0]               vec_regs;
  logic [3:0]               fp_regs;
  logic [3:0]               media_regs;
  int                       n_errors = 0;
  int                       n_compared = 0;
  fed_row_type              rows [7];

  always #25 clock = ~clock;

  fed_front_end DUT (.i_clock(clock), .i_rst_n(rst_n), .i_ce(ce), .i_long_mode(long_mode),
    .i_redirect(redirect), .i_redirect_addr(redirect_addr), .i_pkt_valid(pkt_valid),
    .i_pkt_data(pkt_data), .i_dec_ready(dec_ready), .i_vcsw(vcsw), .i_vec_chk(vec_chk),
    .i_vec_addr_lo(addr_lo), .o_fetch_req(fetch_req), .o_fetch_addr(fetch_addr),
    .o_slot(slot), .o_gp_fault(gp_fault), .o_vec_regs(vec_regs), .o_fp_regs(fp_regs),
    .o_media_regs(media_regs));
  fed_icache_model cache (.i_clock(clock), .i_rst_n(rst_n), .i_req(fetch_req),
    .i_addr(fetch_addr), .i_image(image), .i_delay(delay), .o_valid(pkt_valid),
    .o_data(pkt_data));

  task stop_test;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait: 0 for a decoded group, 1 for a fetch request
  task wait_on(input int which);
    int k;
    for (k = 0; k < 20; k++) begin
      if ((which == 0 ? slot[0].valid : fetch_req) === 1'b1) break;
      @(posedge clock);
      #1;
    end
    if (k == 20) begin
      check(64'h0, 64'h1);
      stop_test;
    end
  endtask

  task redir(input logic [63:0] a);
    @(posedge clock);
    redirect <= 1'b1;
    redirect_addr <= a;
    @(posedge clock);
    redirect <= 1'b0;
    #1;
    check({fetch_req, fetch_addr[62:0]}, {1'b1, a[62:5], 5'h00});
  endtask

  // Flags: load_op, is_acmp, wide64, zext, ext_pfx, illegal
  function automatic fed_slot_type slot_e(fed_path_type p, logic [2:0] ln, logic [2:0] lt,
                                          logic [5:0] f, logic [3:0] r);
    slot_e = {1'b1, p, ln, lt, f[5:1], r, f[0]};
  endfunction

  initial begin
    rows[0] = '{1'b1, 32'h9090_0003, slot_e(single_decode_fast_path, 3'h2, 3'h1, 6'h24, 4'h0)};
    rows[1] = '{1'b1, 32'h90C3_0348, slot_e(single_decode_fast_path, 3'h3, 3'h1, 6'h0A, 4'h0)};
    rows[2] = '{1'b1, 32'h9000_0344, slot_e(single_decode_fast_path, 3'h3, 3'h1, 6'h26, 4'h8)};
    rows[3] = '{1'b1, 32'h9090_088D, slot_e(single_macro_op_path, 3'h2, 3'h2, 6'h14, 4'h1)};
    rows[4] = '{1'b1, 32'h9000_8D66, slot_e(microcode_sequenced_path, 3'h3, 3'h4, 6'h10, 4'h0)};
    rows[5] = '{1'b0, 32'h90C3_0348, slot_e(microcode_sequenced_path, 3'h2, 3'h4, 6'h01, 4'h0)};
    rows[6] = '{1'b1, 32'h9090_0058, slot_e(single_macro_op_path, 3'h2, 3'h1, 6'h20, 4'h0)};
    @(posedge clock);
    #1;
    check({fetch_req, fetch_addr[60:0], slot[0].valid, gp_fault}, 64'h0);
    check(64'({vec_regs, fp_regs, media_regs}), 64'h888);
    @(posedge clock);
    rst_n <= 1'b1;
    dec_ready <= 1'b1;
    for (int r = 0; r < 7; r++) begin
      @(posedge clock);
      long_mode <= rows[r].lm;
      image <= {{23{8'h90}}, rows[r].code, {5{8'h90}}};
      redir(64'h1000_0025 + 64'(r) * 64'h40);
      wait_on(0);
      check(64'(slot[0]), 64'(rows[r].exp));
      check(64'(vec_regs), rows[r].lm ? 64'h10 : 64'h08);
    end
    // Sixteen load-op forms fill one window, slow cache
    @(posedge clock);
    delay <= 4'h3;
    image <= {16{16'h0003}};
    redir(64'h2000_0000);
    wait_on(0);
    for (int g = 0; g < 4; g++) begin
      for (int i = 0; i < SLOTS; i++) check(64'({slot[i].valid, slot[i].path}), 64'h4);
      @(posedge clock);
      #1;
    end
    check(64'(slot[0].valid), 64'h0);
    wait_on(1);
    check(fetch_addr, 64'h2000_0020);
    @(posedge clock);
    dec_ready <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      @(posedge clock);
      #1;
      check(64'(slot[0].valid), 64'h0);
    end
    @(posedge clock);
    dec_ready <= 1'b1;
    #1;
    wait_on(0);
    check(64'(slot[0]), 64'(rows[0].exp));
    // Clock enable low must hold the last group and the window position
    @(posedge clock);
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check(64'({slot[0].valid, fetch_req, vec_regs}), 64'h50);
    @(posedge clock);
    ce <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      vec_chk <= 1'b1;
      addr_lo <= k[0] ? 4'h1 : 4'h0;
      vcsw <= {14'h0, k[1], 17'h0};
      @(posedge clock);
      vec_chk <= 1'b0;
      #1;
      check(64'(gp_fault), 64'(k == 1));
    end
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1;
    check(64'({fetch_req, slot[0].valid, vec_regs}), 64'h8);
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    check({fetch_req, fetch_addr[62:0]}, {1'b1, RESET_FETCH_ADDR[62:0]});
    stop_test;
  end
endmodule
`default_nettype wire

// file: bench/fed_icache_model.sv
// Instruction cache model offering 32-byte packets on request
`timescale 1ns/1ps
`default_nettype none
module fed_icache_model
  import fed_pkg::*;
(
  input  wire logic                i_clock,  // Core clock
  input  wire logic                i_rst_n,  // Sync reset, active low
  input  wire logic                i_req,    // Packet request
  input  wire logic [63:0]         i_addr,   // Packet address
  input  wire logic [PKT_BITS-1:0] i_image,  // Bytes to return
  input  wire logic [3:0]          i_delay,  // Wait cycles before offer
  output logic                     o_valid,  // Packet offered
  output logic      [PKT_BITS-1:0] o_data    // Packet bytes
);
  logic [3:0]  cnt_r;
  logic [63:0] addr_r;
  logic        taken;
  logic        moved;
  assign taken = o_valid && i_req;
  assign moved = o_valid && (i_addr != addr_r);
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_data  <= '0;
      cnt_r   <= 4'h0;
    end else if (taken || moved) begin
      // Released bus must not keep showing the last packet
      o_valid <= 1'b0;
      o_data  <= ~o_data;
      cnt_r   <= 4'h0;
    end else if (i_req && !o_valid) begin
      if (cnt_r >= i_delay) begin
        o_valid <= 1'b1;
        o_data  <= i_image;
        addr_r  <= i_addr;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/fed_front_end.sv
// Instruction fetch, pick window and operand-width decode front end
`timescale 1ns/1ps
`default_nettype none
module fed_front_end
  import fed_pkg::*;
(
  input  wire logic                i_clock,         // Core clock, 20 MHz
  input  wire logic                i_rst_n,         // Sync reset, active low
  input  wire logic                i_ce,            // Clock enable
  input  wire logic                i_long_mode,     // 64-bit mode active
  input  wire logic                i_redirect,      // Restart fetch, pulse
  input  wire logic [63:0]         i_redirect_addr, // Restart byte address
  input  wire logic                i_pkt_valid,     // Cache packet ready
  input  wire logic [PKT_BITS-1:0] i_pkt_data,      // Cache packet bytes
  input  wire logic                i_dec_ready,     // Downstream takes group
  input  wire logic [31:0]         i_vcsw,          // Vector control word
  input  wire logic                i_vec_chk,       // Vector load-op check
  input  wire logic [VEC_ALIGN_W-1:0] i_vec_addr_lo, // Operand addr low bits
  output logic                     o_fetch_req,     // Packet request
  output logic [63:0]              o_fetch_addr,    // Aligned packet addr
  output fed_slot_type [SLOTS-1:0] o_slot,          // Decoded group
  output logic                     o_gp_fault,      // Protection fault
  output logic [4:0]               o_vec_regs,      // Vector regs usable
  output logic [3:0]               o_fp_regs,       // FP stack regs
  output logic [3:0]               o_media_regs     // 64-bit media regs
);
  fed_state_type state_r, state_nxt;
  logic [OFF_W-1:0] off_r, off_nxt;
  logic [63:0] addr_r, addr_nxt;
  logic req_r, req_nxt;
  fed_slot_type [SLOTS-1:0] slot_r, slot_nxt;
  logic gp_r;
  logic [4:0] vec_r;
  logic [3:0] fp_r;
  logic [3:0] media_r;
  logic [PKT_BITS-1:0] win_w;
  logic [OFF_W-1:0] off_w [SLOTS+1];
  fed_slot_type dec_w [SLOTS];
  logic take_w [SLOTS];
  logic fit_w [SLOTS];
  wire logic accept_w;
  wire logic any_w;
  wire logic misalign_w;
  wire logic gp_nxt_w;

  // Packet taken only while a request stands and no redirect overrides it
  assign accept_w = (state_r == ST_FETCH) && req_r && i_pkt_valid && !i_redirect;
  assign any_w    = take_w[0];

  fed_pick_mem u_win (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_wr    (accept_w),
    .i_wdata (i_pkt_data),
    .o_rdata (win_w)
  );

  // Chained length decode across the window, up to four per cycle
  assign off_w[0] = off_r;
  genvar k;
  generate
    for (k = 0; k < SLOTS; k++) begin : g_slot
      assign dec_w[k] = dec_at(win_w, off_w[k], i_long_mode);
      assign fit_w[k] = ({1'b0, off_w[k]} + {4'h0, dec_w[k].len}) <= {1'b0, WIN_END};
      if (k == 0) begin : g_first
        // A microcoded form may only lead, and then goes alone
        assign take_w[k] = fit_w[k];
      end else begin : g_next
        assign take_w[k] = take_w[k-1] && fit_w[k]
                         && (dec_w[k-1].path != microcode_sequenced_path)
                         && (dec_w[k].path != microcode_sequenced_path);
      end
      assign off_w[k+1] = take_w[k] ? off_w[k] + {3'h0, dec_w[k].len} : off_w[k];
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    off_nxt   = off_r;
    addr_nxt  = addr_r;
    req_nxt   = req_r;
    slot_nxt  = '0;
    if (i_redirect) begin
      // Packet base is always aligned; entry point kept as window offset
      addr_nxt  = {i_redirect_addr[63:ALIGN_W], 5'h00};
      off_nxt   = {1'b0, i_redirect_addr[ALIGN_W-1:0]};
      req_nxt   = 1'b1;
      state_nxt = ST_FETCH;
    end else begin
      unique case (state_r)
        ST_FETCH: begin
          req_nxt = 1'b1;
          if (accept_w) begin
            addr_nxt  = addr_r + PKT_STEP;
            req_nxt   = 1'b0;
            state_nxt = ST_PICK;
          end
        end
        ST_PICK: begin
          if (!any_w) begin
            // Bytes that cannot form a whole instruction are dropped
            off_nxt   = OFF_RESET;
            req_nxt   = 1'b1;
            state_nxt = ST_FETCH;
          end else if (i_dec_ready) begin
            off_nxt = off_w[SLOTS];
            for (int j = 0; j < SLOTS; j++) begin
              slot_nxt[j]       = dec_w[j];
              slot_nxt[j].valid = take_w[j];
            end
          end
        end
      endcase
    end
  end

  // Unaligned vector operand faults unless the mask bit is set
  assign misalign_w = (i_vec_addr_lo != '0);
  assign gp_nxt_w   = i_vec_chk && misalign_w && !i_vcsw[MISALIGN_MASK_BIT];

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= ST_FETCH;
      off_r   <= OFF_RESET;
      addr_r  <= RESET_FETCH_ADDR;
      req_r   <= 1'b0;
      slot_r  <= '0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      off_r   <= off_nxt;
      addr_r  <= addr_nxt;
      req_r   <= req_nxt;
      slot_r  <= slot_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      gp_r    <= 1'b0;
      vec_r   <= VEC_REGS_LEGACY;
      fp_r    <= FP_STACK_REGS;
      media_r <= MEDIA64_REGS;
    end else if (i_ce) begin
      gp_r    <= gp_nxt_w;
      vec_r   <= i_long_mode ? VEC_REGS_LONG : VEC_REGS_LEGACY;
      fp_r    <= FP_STACK_REGS;
      media_r <= MEDIA64_REGS;
    end
  end

  assign o_fetch_req  = req_r;
  assign o_fetch_addr = addr_r;
  assign o_slot       = slot_r;
  assign o_gp_fault   = gp_r;
  assign o_vec_regs   = vec_r;
  // Architectural limit, not a mode: registered so every output is a flop
  assign o_fp_regs    = fp_r;
  assign o_media_regs = media_r;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  fetch_align_a: assert property (
    o_fetch_req |-> (o_fetch_addr[ALIGN_W-1:0] == 5'h00))
    else $error("fetch address not packet aligned");

  pkt_step_a: assert property (
    (i_ce && accept_w) |=> (o_fetch_addr == $past(o_fetch_addr) + PKT_STEP))
    else $error("fetch address did not step one packet");

  window_fill_a: assert property (
    (i_ce && accept_w) |=> (state_r == ST_PICK) && (win_w == $past(i_pkt_data)))
    else $error("packet not merged into pick window");

  fast_group_a: assert property (
    o_slot[SLOTS-1].valid |-> o_slot[0].valid && o_slot[1].valid && o_slot[2].valid
      && (o_slot[0].path != microcode_sequenced_path))
    else $error("four-wide group malformed");

  load_op_fast_a: assert property (
    (o_slot[0].valid && o_slot[0].load_op && !o_slot[0].is_acmp
      && o_slot[0].path != single_macro_op_path && !o_slot[0].illegal)
      |-> (o_slot[0].path == single_decode_fast_path) && (o_slot[0].lat == LAT_FAST))
    else $error("integer load-op not on fast path");

  addr_fast_a: assert property (
    (o_slot[0].valid && o_slot[0].is_acmp && o_slot[0].path == single_macro_op_path)
      |-> (o_slot[0].lat == 3'h2))
    else $error("wide address-compute latency wrong");

  addr_ucode_a: assert property (
    (o_slot[0].valid && o_slot[0].path == microcode_sequenced_path)
      |-> !o_slot[1].valid && (o_slot[0].lat > LAT_ACMP))
    else $error("microcoded form not issued alone");

  zero_ext_a: assert property (
    (i_ce && !i_redirect && state_r == ST_PICK && i_dec_ready && take_w[0] && i_long_mode
      && dec_w[0].is_acmp && !dec_w[0].wide64 && dec_w[0].len == 3'h2)
      |=> o_slot[0].zext)
    else $error("32-bit write did not zero-extend");

  ext_prefix_a: assert property (
    (o_slot[0].valid && (o_slot[0].wide64 || o_slot[0].reg_idx[3]))
      |-> o_slot[0].ext_pfx)
    else $error("wide or upper register without prefix");

  vec_count_a: assert property (
    i_ce |=> (o_vec_regs == ($past(i_long_mode) ? 5'h10 : 5'h08)))
    else $error("vector register count wrong");

  fp_count_a: assert property (
    (o_fp_regs == 4'h8) && (o_media_regs == 4'h8))
    else $error("stack or media register count wrong");

  mask_quiet_a: assert property (
    (i_ce && i_vec_chk && i_vcsw[MISALIGN_MASK_BIT]) |=> !o_gp_fault)
    else $error("masked misalignment raised a fault");

  mask_fault_a: assert property (
    (i_ce && i_vec_chk && i_vec_addr_lo != 4'h0 && !i_vcsw[MISALIGN_MASK_BIT])
      |=> o_gp_fault)
    else $error("unmasked misalignment did not fault");
endmodule
`default_nettype wire

// file: rtl/fed_pick_mem.sv
// Pick window storage: one 32-byte packet, read data held in a register
`timescale 1ns/1ps
`default_nettype none
module fed_pick_mem
  import fed_pkg::*;
(
  input  wire logic                i_clock,  // Core clock
  input  wire logic                i_rst_n,  // Sync reset, active low
  input  wire logic                i_ce,     // Clock enable
  input  wire logic                i_wr,     // Load a new packet
  input  wire logic [PKT_BITS-1:0] i_wdata,  // Packet bytes
  output logic      [PKT_BITS-1:0] o_rdata   // Window contents
);
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_ce && i_wr) begin
      o_rdata <= i_wdata;
    end
  end
endmodule
`default_nettype wire

// file: rtl/fed_pkg.sv
// Shared constants, types and decode helpers for the fetch/decode front end
// How it works
// - Fetch reads 32-byte aligned instruction packets
// - Packet bytes merge into 32-byte pick window
// - Load-op integer forms decode fast, four per cycle
// - Wide address-compute forms single path, two cycles
// - 16-bit address-compute form goes through microcode
// - 32-bit writes in long mode zero upper half
// - 64-bit operands in long mode need extension prefix
// - Upper eight registers also need extension prefix
// - Long mode gives sixteen vector registers, else eight
// - FP stack and 64-bit media keep eight registers
// - Misalignment mask suppresses vector protection faults
package fed_pkg;
  localparam int unsigned PKT_BYTES = 32;
  localparam int unsigned PKT_BITS  = PKT_BYTES * 8;
  localparam int unsigned ALIGN_W   = 5;
  localparam int unsigned OFF_W     = 6;
  localparam int unsigned SLOTS     = 4;
  localparam logic [63:0] RESET_FETCH_ADDR = 64'h0000_0000_0000_0000;
  localparam logic [OFF_W-1:0] WIN_END = 6'h20;
  localparam logic [OFF_W-1:0] OFF_RESET = 6'h00;
  localparam logic [63:0] PKT_STEP = 64'h0000_0000_0000_0020;
  localparam logic [7:0] OPSIZE_PFX   = 8'h66;
  localparam logic [3:0] EXT_PFX_HI   = 4'h4;
  localparam logic [7:0] OPC_ADD_LD   = 8'h03;
  localparam logic [7:0] OPC_ADDR_CMP = 8'h8D;
  localparam logic [7:0] OPC_VEC_LDOP = 8'h58;
  localparam logic [7:0] OPC_NOP      = 8'h90;
  localparam int unsigned EXT_W_BIT = 3;
  localparam int unsigned EXT_R_BIT = 2;
  localparam logic [2:0] LAT_FAST   = 3'h1;
  localparam logic [2:0] LAT_ACMP   = 3'h2;
  localparam logic [2:0] LAT_UCODE  = 3'h4;
  localparam logic [4:0] VEC_REGS_LONG   = 5'h10;
  localparam logic [4:0] VEC_REGS_LEGACY = 5'h08;
  localparam logic [3:0] FP_STACK_REGS   = 4'h8;
  localparam logic [3:0] MEDIA64_REGS    = 4'h8;
  localparam int unsigned MISALIGN_MASK_BIT = 17;
  localparam int unsigned VEC_ALIGN_W = 4;

  typedef enum logic [1:0] {
    single_decode_fast_path,
    single_macro_op_path,
    microcode_sequenced_path
  } fed_path_type;

  typedef enum logic [0:0] {ST_FETCH, ST_PICK} fed_state_type;

  typedef struct packed {
    logic         valid;
    fed_path_type path;
    logic [2:0]   len;
    logic [2:0]   lat;
    logic         load_op;
    logic         is_acmp;
    logic         wide64;
    logic         zext;
    logic         ext_pfx;
    logic [3:0]   reg_idx;
    logic         illegal;
  } fed_slot_type;

  function automatic logic [7:0] win_byte(logic [PKT_BITS-1:0] win,
                                          logic [OFF_W-1:0] idx);
    win_byte = (idx < WIN_END) ? win[{idx[ALIGN_W-1:0], 3'h0} +: 8] : 8'h00;
  endfunction

  function automatic fed_slot_type dec_at(logic [PKT_BITS-1:0] win,
                                          logic [OFF_W-1:0] off,
                                          logic lm);
    fed_slot_type s;
    logic [OFF_W-1:0] i;
    logic [7:0] b, op, mrm;
    logic p66, ext;
    logic [3:0] pfx;
    s = '0;
    i = off;
    b = win_byte(win, i);
    p66 = (b == OPSIZE_PFX);
    if (p66) i = i + 6'h01;
    b = win_byte(win, i);
    ext = lm && (b[7:4] == EXT_PFX_HI);
    pfx = ext ? b[3:0] : 4'h0;
    if (ext) i = i + 6'h01;
    op  = win_byte(win, i);
    mrm = win_byte(win, i + 6'h01);
    s.valid   = 1'b1;
    s.ext_pfx = ext;
    s.wide64  = ext && pfx[EXT_W_BIT];
    s.reg_idx = {ext && pfx[EXT_R_BIT], mrm[5:3]};
    s.len     = (op == OPC_NOP) ? 3'(i - off + 6'h01) : 3'(i - off + 6'h02);
    s.lat     = LAT_FAST;
    s.path    = single_decode_fast_path;
    if (op == OPC_NOP) begin
      s.reg_idx = 4'h0;
    end else if (op == OPC_ADD_LD) begin
      s.load_op = (mrm[7:6] != 2'h3);
      s.zext    = lm && !s.wide64 && !p66;
    end else if (op == OPC_ADDR_CMP) begin
      s.is_acmp = 1'b1;
      s.zext    = lm && !s.wide64 && !p66;
      s.path    = p66 ? microcode_sequenced_path : single_macro_op_path;
      s.lat     = p66 ? LAT_UCODE : LAT_ACMP;
    end else if (op == OPC_VEC_LDOP) begin
      s.load_op = (mrm[7:6] != 2'h3);
      s.path    = single_macro_op_path;
    end else begin
      s.illegal = 1'b1;
      s.path    = microcode_sequenced_path;
      s.lat     = LAT_UCODE;
    end
    dec_at = s;
  endfunction
endpackage
